// >>> rtl/lcdw_top.v
// The address-and-strobe port and the placing of the registers were decided locally.
`include "lcdw_defs.vh"

module lcdw_top #(
	parameter [6:0]  SLV_ADDR  = `LCDW_SLV_ADDR,
	parameter [18:0] DIV_N1    = `LCDW_BLK_N1,
	parameter [18:0] DIV_N2    = `LCDW_BLK_N2,
	parameter [18:0] DIV_N3    = `LCDW_BLK_N3,
	parameter [18:0] DIV_L1    = `LCDW_BLK_L1,
	parameter [18:0] DIV_L2    = `LCDW_BLK_L2,
	parameter [18:0] DIV_L3    = `LCDW_BLK_L3,
	parameter [7:0]  PROC_NORM = `LCDW_PROC_NORM,
	parameter [7:0]  PROC_LP   = `LCDW_PROC_LP,
	parameter [11:0] PHASE_CYC = `LCDW_PHASE_CYC
) (
	// Clock and reset
	input  wire        CLK_I,
	input  wire        SYS_RST_I,
	// Two-wire bus
	input  wire        SCL_I,
	output reg         SCL_O,
	output reg         SCL_OE_O,
	input  wire        SDA_I,
	output reg         SDA_O,
	output reg         SDA_OE_O,
	// Hardware subaddress pins
	input  wire        HW_SUBADDR_PIN_LSB_I,
	input  wire        HW_SUBADDR_PIN_MID_I,
	input  wire        HW_SUBADDR_PIN_MSB_I,
	// Register port
	input  wire [7:0]  REG_ADDR_I,
	input  wire [15:0] REG_WDATA_I,
	input  wire        REG_WR_I,
	input  wire        REG_RD_I,
	output reg  [15:0] REG_RDATA_O,
	// Display register
	output reg  [39:0] SEG_O,
	output reg  [1:0]  BP_PHASE_O
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_ADDR = 5'h02;
	localparam [4:0] ST_CMD  = 5'h04;
	localparam [4:0] ST_DATA = 5'h08;
	localparam [4:0] ST_SKIP = 5'h10;

	// Bit k of the byte (k=0 is MSB) -> {column offset, row}
	function [4:0] lcdw_map;
		input [1:0] drv;
		input       ib;
		input [2:0] k;
		reg   [2:0] t;
		begin
			t = 3'h0;
			case (drv)
				`LCDW_DRV_STATIC: lcdw_map = {k, ib, 1'b0};
				`LCDW_DRV_MUX2:   lcdw_map = {1'b0, k[2:1], ib, k[0]};
				`LCDW_DRV_MUX3: begin
					if (k < 3'h3) begin
						lcdw_map = {3'h0, k[1:0]};
					end else if (k < 3'h6) begin
						t        = k - 3'h3;
						lcdw_map = {3'h1, t[1:0]};
					end else begin
						t        = k - 3'h6;
						lcdw_map = {3'h2, t[1:0]};
					end
				end
				default:          lcdw_map = {2'h0, k[2], k[1:0]};
			endcase
		end
	endfunction

	reg  [4:0]  state;
	reg         scl_q;
	reg         sda_q;
	reg  [3:0]  bit_cnt;
	reg         in_ack;
	reg  [7:0]  shift;
	reg  [7:0]  proc_cnt;
	reg  [5:0]  ptr;
	reg  [2:0]  sub;
	reg  [1:0]  drv;
	reg         bias;
	reg         disp_en;
	reg         lp;
	reg         in_bank;
	reg         out_bank;
	reg  [1:0]  blink_rate;
	reg         blink_alt;
	reg         slv_en;
	reg  [1:0]  phase;
	reg  [11:0] phase_cnt;
	reg  [3:0]  ram [0:`LCDW_NCOL - 7'h01];
	reg  [6:0]  inc;
	reg  [1:0]  last_phase;
	reg  [15:0] next_rdata;
	wire        blink_tog;
	wire [2:0]  hw_sub = {HW_SUBADDR_PIN_MSB_I, HW_SUBADDR_PIN_MID_I, HW_SUBADDR_PIN_LSB_I};
	wire        scl_rise = SCL_I & ~scl_q;
	wire        scl_fall = ~SCL_I & scl_q;
	wire        start_c  = scl_q & SCL_I & sda_q & ~SDA_I;
	wire        stop_c   = scl_q & SCL_I & ~sda_q & SDA_I;
	wire        byte_end = scl_fall & ~in_ack & (bit_cnt == `LCDW_BYTE_BITS);
	wire        store    = byte_end & (state == ST_DATA);
	wire        alt_ok   = (drv == `LCDW_DRV_STATIC) | (drv == `LCDW_DRV_MUX2);
	// banks only in static and 1:2
	wire        ib_eff   = in_bank & alt_ok;
	wire        ob_eff   = alt_ok & (out_bank ^ (blink_alt & blink_tog));
	wire [1:0]  row_sel  = phase + {ob_eff, 1'b0};
	wire        blank    = ~disp_en | (blink_tog & ~(blink_alt & alt_ok));
	wire        sub_hit  = (sub == hw_sub);
	wire [2:0]  sub_nxt  = sub + 3'h1;
	wire        next_hit = (sub_nxt == hw_sub);
	wire [6:0]  ptr_adv  = {1'b0, ptr} + inc;
	wire [6:0]  ptr_wrap = ptr_adv - `LCDW_NCOL;
	wire [55:0] tgt_flat;
	wire [15:0] row_flat;
	wire [39:0] next_seg;

	always @* begin
		case (drv)
			`LCDW_DRV_STATIC: inc = `LCDW_INC_STATIC;
			`LCDW_DRV_MUX2:   inc = `LCDW_INC_MUX2;
			`LCDW_DRV_MUX3:   inc = `LCDW_INC_MUX3;
			default:          inc = `LCDW_INC_MUX4;
		endcase
	end

	always @* begin
		case (drv)
			`LCDW_DRV_STATIC: last_phase = 2'h0;
			`LCDW_DRV_MUX2:   last_phase = 2'h1;
			`LCDW_DRV_MUX3:   last_phase = 2'h2;
			default:          last_phase = 2'h3;
		endcase
	end

	// Per-bit target column and row
	genvar gk;
	generate
		for (gk = 0; gk < `LCDW_BYTE_BITS; gk = gk + 1) begin : g_bit
			localparam [2:0] KI = gk;
			wire [4:0] m = lcdw_map(drv, ib_eff, KI);
			// input bank row offset inside the map
			assign tgt_flat[7*gk +: 7] = {1'b0, ptr} + {4'h0, m[4:2]};
			assign row_flat[2*gk +: 2] = m[1:0];
		end
	endgenerate

	// display RAM, one 4-bit word per segment column
	genvar gc;
	generate
		for (gc = 0; gc < `LCDW_NCOL; gc = gc + 1) begin : g_col
			localparam [6:0] CI = gc;
			integer k;
			always @(posedge CLK_I) begin
				if (SYS_RST_I) begin
					ram[gc] <= 4'h0;
				end else if (store) begin
					for (k = 0; k < 8; k = k + 1) begin
						// store on own subaddress, wrapped part to next
						if ((tgt_flat[7*k +: 7] == CI && sub_hit) ||
						    (tgt_flat[7*k +: 7] == CI + `LCDW_NCOL && next_hit))
							ram[gc][row_flat[2*k +: 2]] <= shift[7-k];
					end
				end
			end
			assign next_seg[gc] = ram[gc][row_sel];
		end
	endgenerate

	// Bus receiver and command execution
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			state      <= ST_IDLE;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			bit_cnt    <= 4'h0;
			in_ack     <= 1'b0;
			shift      <= 8'h00;
			proc_cnt   <= 8'h00;
			ptr        <= 6'h00;
			sub        <= 3'h0;
			drv        <= `LCDW_DRV_MUX4;
			bias       <= 1'b0;
			disp_en    <= 1'b0;
			lp         <= 1'b0;
			in_bank    <= 1'b0;
			out_bank   <= 1'b0;
			blink_rate <= 2'h0;
			blink_alt  <= 1'b0;
			SDA_O      <= 1'b0;
			SDA_OE_O   <= 1'b0;
			SCL_O      <= 1'b0;
			SCL_OE_O   <= 1'b0;
		end else begin
			scl_q <= SCL_I;
			sda_q <= SDA_I;
			if (proc_cnt != 8'h00)
				proc_cnt <= proc_cnt - 8'h01;
			SCL_OE_O <= (proc_cnt > 8'h01);
			if (start_c) begin
				state    <= ST_ADDR;
				bit_cnt  <= 4'h0;
				in_ack   <= 1'b0;
				SDA_OE_O <= 1'b0;
			end else if (stop_c) begin
				// pointer kept as is after a cut transfer
				state    <= ST_IDLE;
				bit_cnt  <= 4'h0;
				in_ack   <= 1'b0;
				SDA_OE_O <= 1'b0;
			end else if (state != ST_IDLE) begin
				if (scl_rise && bit_cnt < `LCDW_BYTE_BITS && !in_ack) begin
					shift   <= {shift[6:0], SDA_I};
					bit_cnt <= bit_cnt + 4'h1;
				end
				if (byte_end) begin
					in_ack   <= 1'b1;
					proc_cnt <= lp ? PROC_LP : PROC_NORM;
					case (state)
						ST_ADDR: begin
							if (shift[7:1] == SLV_ADDR && !shift[0] && slv_en) begin
								state    <= ST_CMD;
								SDA_OE_O <= 1'b1;
							end else begin
								state <= ST_SKIP;
							end
						end
						ST_CMD: begin
							SDA_OE_O <= 1'b1;
							if (!shift[`LCDW_CONT_BIT])
								state <= ST_DATA;
							if (!shift[`LCDW_OPC_PTR]) begin
								ptr <= shift[`LCDW_PTR_FIELD];
							end else if (shift[`LCDW_OPC_MODE] == `LCDW_CODE_MODE) begin
								// display enable writable at any rate
								lp      <= shift[`LCDW_MS_LP];
								disp_en <= shift[`LCDW_MS_E];
								bias    <= shift[`LCDW_MS_B];
								drv     <= shift[`LCDW_MS_DRV];
							end else if (shift[`LCDW_OPC_SEL] == `LCDW_CODE_DEV) begin
								sub <= shift[`LCDW_DS_SUB];
							end else if (shift[`LCDW_OPC_SEL] == `LCDW_CODE_BLINK) begin
								blink_alt  <= shift[`LCDW_BL_ALT];
								blink_rate <= shift[`LCDW_BL_RATE];
							end else if (shift[`LCDW_OPC_BANK] == `LCDW_CODE_BANK) begin
								in_bank  <= shift[`LCDW_BS_IN];
								out_bank <= shift[`LCDW_BS_OUT];
							end
						end
						ST_DATA: begin
							// only the matching device answers data
							SDA_OE_O <= sub_hit;
							if (ptr_adv >= `LCDW_NCOL) begin
								ptr <= ptr_wrap[5:0];
								sub <= sub + 3'h1;
							end else begin
								ptr <= ptr_adv[5:0];
							end
						end
						default: state <= state;
					endcase
				end else if (scl_fall && in_ack) begin
					in_ack   <= 1'b0;
					bit_cnt  <= 4'h0;
					SDA_OE_O <= 1'b0;
				end
			end
		end
	end

	// Register port
	always @(posedge CLK_I) begin
		if (SYS_RST_I)
			slv_en <= `LCDW_CTRL_RST;
		else if (REG_WR_I && REG_ADDR_I == `LCDW_OFF_CTRL)
			slv_en <= REG_WDATA_I[`LCDW_CTRL_EN];
	end

	always @* begin
		case (REG_ADDR_I)
			`LCDW_OFF_CTRL:  next_rdata = {15'h0000, slv_en};
			`LCDW_OFF_STAT0: next_rdata = {5'h00, sub, 2'h0, ptr};
			`LCDW_OFF_STAT1: next_rdata = {4'h0, state != ST_IDLE, blink_tog, blink_alt,
			                               blink_rate, in_bank, out_bank, lp, disp_en,
			                               bias, drv};
			default:         next_rdata = 16'h0000;
		endcase
	end

	always @(posedge CLK_I) begin
		if (SYS_RST_I)
			REG_RDATA_O <= 16'h0000;
		else
			REG_RDATA_O <= REG_RD_I ? next_rdata : 16'h0000;
	end

	lcdw_blink #(
		.DIV_N1 (DIV_N1),
		.DIV_N2 (DIV_N2),
		.DIV_N3 (DIV_N3),
		.DIV_L1 (DIV_L1),
		.DIV_L2 (DIV_L2),
		.DIV_L3 (DIV_L3)
	) u_blink (
		.clk_i  (CLK_I),
		.rst_i  (SYS_RST_I),
		.rate_i (blink_rate),
		.lp_i   (lp),
		.tog_o  (blink_tog)
	);

	// multiplex phase sequencing and display register
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			phase      <= 2'h0;
			phase_cnt  <= 12'h000;
			SEG_O      <= 40'h0000000000;
			BP_PHASE_O <= 2'h0;
		end else begin
			if (phase_cnt >= PHASE_CYC - 12'h001) begin
				phase_cnt <= 12'h000;
				phase     <= (phase >= last_phase) ? 2'h0 : phase + 2'h1;
			end else begin
				phase_cnt <= phase_cnt + 12'h001;
			end
			SEG_O      <= blank ? 40'h0000000000 : next_seg;
			BP_PHASE_O <= phase;
		end
	end
endmodule

// >>> pkg/lcdw_defs.vh
`ifndef LCDW_DEFS_VH
`define LCDW_DEFS_VH
// Display RAM size and drive mode codes
`define LCDW_NCOL        7'h28
`define LCDW_DRV_MUX4    2'h0
`define LCDW_DRV_STATIC  2'h1
`define LCDW_DRV_MUX2    2'h2
`define LCDW_DRV_MUX3    2'h3
// Pointer increments per stored byte
`define LCDW_INC_STATIC  7'h08
`define LCDW_INC_MUX2    7'h04
`define LCDW_INC_MUX3    7'h03
`define LCDW_INC_MUX4    7'h02
// Command byte fields
`define LCDW_CONT_BIT    7
`define LCDW_PTR_FIELD   5:0
`define LCDW_OPC_PTR     6
`define LCDW_OPC_MODE    6:5
`define LCDW_OPC_SEL     6:3
`define LCDW_OPC_BANK    6:2
`define LCDW_MS_LP       4
`define LCDW_MS_E        3
`define LCDW_MS_B        2
`define LCDW_MS_DRV      1:0
`define LCDW_DS_SUB      2:0
`define LCDW_BS_IN       1
`define LCDW_BS_OUT      0
`define LCDW_BL_ALT      2
`define LCDW_BL_RATE     1:0
`define LCDW_CODE_MODE   2'h2
`define LCDW_CODE_DEV    4'hC
`define LCDW_CODE_BLINK  4'hE
`define LCDW_CODE_BANK   5'h1E
// Receiver bit counts
`define LCDW_BYTE_BITS   4'h8
// Register map and reset values
`define LCDW_OFF_CTRL    8'h00
`define LCDW_OFF_STAT0   8'h04
`define LCDW_OFF_STAT1   8'h08
`define LCDW_CTRL_RST    1'h1
`define LCDW_CTRL_EN     0
// Blink divisors, normal and power saving
`define LCDW_BLK_N1      19'h16800
`define LCDW_BLK_N2      19'h2D000
`define LCDW_BLK_N3      19'h5A000
`define LCDW_BLK_L1      19'h03C00
`define LCDW_BLK_L2      19'h07800
`define LCDW_BLK_L3      19'h0F000
// Byte processing time and multiplex phase length
`define LCDW_PROC_NORM   8'h01
`define LCDW_PROC_LP     8'h06
`define LCDW_PHASE_CYC   12'h2D0
`define LCDW_SLV_ADDR    7'h38
`endif

// >>> rtl/lcdw_blink.v
`include "lcdw_defs.vh"

module lcdw_blink #(
	parameter [18:0] DIV_N1 = `LCDW_BLK_N1,
	parameter [18:0] DIV_N2 = `LCDW_BLK_N2,
	parameter [18:0] DIV_N3 = `LCDW_BLK_N3,
	parameter [18:0] DIV_L1 = `LCDW_BLK_L1,
	parameter [18:0] DIV_L2 = `LCDW_BLK_L2,
	parameter [18:0] DIV_L3 = `LCDW_BLK_L3
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Blink setting
	input  wire [1:0]  rate_i,
	input  wire        lp_i,
	// Blink phase, high in the off half
	output reg         tog_o
);
	reg  [18:0] cnt;
	reg  [18:0] div;
	wire [18:0] half = {1'b0, div[18:1]};

	// Divisor choice by mode
	always @* begin
		case (rate_i)
			2'h1:    div = lp_i ? DIV_L1 : DIV_N1;
			2'h2:    div = lp_i ? DIV_L2 : DIV_N2;
			2'h3:    div = lp_i ? DIV_L3 : DIV_N3;
			default: div = 19'h00000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i || rate_i == 2'h0) begin
			cnt   <= 19'h00000;
			tog_o <= 1'b0;
		end else if (cnt >= half - 19'h00001) begin
			cnt   <= 19'h00000;
			tog_o <= ~tog_o;
		end else begin
			cnt <= cnt + 19'h00001;
		end
	end
endmodule

// >>> sim/lcdw_top_props.sv
module lcdw_top_props #(
	parameter [7:0] PROC_LP = 8'h06
) (
	input logic        CLK_I,
	input logic        SYS_RST_I,
	input logic        SCL_I,
	input logic        SCL_O,
	input logic        SCL_OE_O,
	input logic        SDA_I,
	input logic        SDA_O,
	input logic        SDA_OE_O,
	input logic        REG_RD_I,
	input logic [15:0] REG_RDATA_O,
	input logic [1:0]  BP_PHASE_O
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] low_run;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	// Cycles the clock line has been held so far
	always @(posedge CLK_I) begin
		if (SYS_RST_I || !SCL_OE_O) begin
			low_run <= 8'h00;
		end else begin
			low_run <= low_run + 8'h01;
		end
	end
	sequence bus_stop;
		SCL_I && $rose(SDA_I);
	endsequence
	sequence ack_on;
		$rose(SDA_OE_O);
	endsequence
	a_sda_only_low: assert property (SDA_OE_O |-> !SDA_O)
		else $error("data line driven high");
	a_ack_edge: assert property (ack_on |-> !SCL_I)
		else $error("ack began with clock high");
	a_ack_stable: assert property (SDA_OE_O && SCL_I |=> SDA_OE_O)
		else $error("ack dropped during clock high");
	a_ack_bound: assert property (ack_on |-> ##[1:200] !SDA_OE_O)
		else $error("ack never released");
	a_stretch_low: assert property (SCL_OE_O |-> !SCL_O)
		else $error("clock line driven high");
	a_stretch_len: assert property ($fell(SCL_OE_O) |-> low_run == PROC_LP - 8'h01)
		else $error("stretch length wrong");
	a_stop_release: assert property (bus_stop |=> (!SDA_OE_O && !SCL_OE_O) [*4])
		else $error("line held after stop");
	a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
		else $error("read data outside its cycle");
	a_phase_step: assert property ($changed(BP_PHASE_O) |->
		BP_PHASE_O == $past(BP_PHASE_O) + 2'h1 || BP_PHASE_O == 2'h0)
		else $error("phase out of order");
endmodule

bind lcdw_top lcdw_top_props #(.PROC_LP(PROC_LP)) u_props (
	.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .SCL_I(SCL_I), .SCL_O(SCL_O),
	.SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
	.REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .BP_PHASE_O(BP_PHASE_O)
);

// >>> sim/lcdw_i2c_mst.sv
module lcdw_i2c_mst #(
	parameter int H = 5
) (
	input  logic clk_i,
	input  logic scl_i,
	input  logic sda_i,
	output logic scl_low_o,
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic scl_high(output logic s);
		int k;
		k = 0;
		scl_low_o <= 1'b0;
		@(posedge clk_i);
		while (!scl_i && k < 100) begin
			@(posedge clk_i);
			k++;
		end
		wait_n(H);
		s = sda_i;
	endtask
	task automatic start();
		sda_low_o <= 1'b1;
		wait_n(H);
		scl_low_o <= 1'b1;
		wait_n(H);
	endtask
	task automatic stop();
		logic s;
		sda_low_o <= 1'b1;
		wait_n(H);
		scl_high(s);
		sda_low_o <= 1'b0;
		wait_n(H);
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 8; i >= 0; i--) begin
			sda_low_o <= (i > 0) ? !b[i - 1] : 1'b0;
			wait_n(H);
			scl_high(s);
			scl_low_o <= 1'b1;
			wait_n(1);
		end
		ack = !s;
	endtask
endmodule

// >>> sim/lcdw_top_tb.sv
module lcdw_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [18:0] DV [6] = '{19'h10, 19'h20, 19'h40, 19'h08, 19'h0C, 19'h14};
	localparam logic [7:0]  MODES [4] = '{8'hC9, 8'hCA, 8'hCB, 8'hC8};
	localparam logic [5:0]  INC [4] = '{6'h08, 6'h04, 6'h03, 6'h02};
	logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic        scl_low, sda_low, scl_o, scl_oe, sda_o, sda_oe;
	logic [2:0]  pins;
	logic [7:0]  reg_addr = 8'h00, d1, d2, d3;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [15:0] exp_q[$];
	logic [39:0] seg, e;
	logic [1:0]  bp;
	int          bad_count = 0, compares = 0;
	wire         scl_line = ~scl_low & ~(scl_oe & ~scl_o);
	wire         sda_line = ~sda_low & ~(sda_oe & ~sda_o);

	always #20 clk = ~clk;

	lcdw_top #(.DIV_N1(DV[0]), .DIV_N2(DV[1]), .DIV_N3(DV[2]), .DIV_L1(DV[3]),
		.DIV_L2(DV[4]), .DIV_L3(DV[5]), .PHASE_CYC(12'h004)) u_dut (
		.CLK_I(clk), .SYS_RST_I(rst), .SCL_I(scl_line), .SCL_O(scl_o), .SCL_OE_O(scl_oe),
		.SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .HW_SUBADDR_PIN_LSB_I(pins[0]),
		.HW_SUBADDR_PIN_MID_I(pins[1]), .HW_SUBADDR_PIN_MSB_I(pins[2]), .REG_ADDR_I(reg_addr),
		.REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
		.REG_RDATA_O(reg_rdata), .SEG_O(seg), .BP_PHASE_O(bp));

	lcdw_i2c_mst u_mst (.clk_i(clk), .scl_i(scl_line), .sda_i(sda_line),
		.scl_low_o(scl_low), .sda_low_o(sda_low));

	task automatic check_val(input logic [39:0] got, input logic [39:0] exp, input string w);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	// Column order on the display is the reverse of bit order in a byte
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev8[i] = v[7 - i];
	endfunction

	task automatic final_report();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Read data notes its expectation; the monitor compares
	task automatic reg_op(input logic w, input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		if (!w) exp_q.push_back(d);
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask

	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d) check_val(40'(reg_rdata), 40'(exp_q.pop_front()), "reg");
	end

	task automatic send(input logic [7:0] b[$], input int skip);
		logic a;
		u_mst.start();
		foreach (b[i]) begin
			u_mst.put(b[i], a);
			if (i != skip) check_val(40'(a), 40'h1, "ack");
		end
		u_mst.stop();
		repeat (4) @(posedge clk);
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		final_report();
	end

	initial begin
		logic a;
		int   k, n;
		void'($urandom(32'h4d4bf757));
		pins = 3'h1 + 3'($urandom % 6);
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		d3 = 8'($urandom) | 8'h01;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check_val(seg, 40'h0, "seg");
		reg_op(0, 8'h00, 16'h0001);
		reg_op(0, 8'h08, 16'h0000);
		reg_op(1, 8'h04, 16'hFFFF);
		reg_op(0, 8'h04, 16'h0000);
		reg_op(0, 8'h0C, 16'h0000);
		reg_op(1, 8'h00, 16'h0000);
		u_mst.start();
		u_mst.put(8'h70, a);
		check_val(40'(a), 40'h0, "ack");
		u_mst.stop();
		reg_op(1, 8'h00, 16'h0001);
		// Spill from the neighbour subaddress into this device
		send('{8'h70, 8'hC9, {5'h1C, pins - 3'h1}, 8'h24, d1, d2}, 4);
		reg_op(0, 8'h04, {5'h0, pins, 8'h0C});
		e = {28'h0, rev8(d2), 4'h0} | {32'h0, rev8({d1[3:0], 4'h0})};
		check_val(seg, e, "seg");
		send('{8'h70, 8'hFA, 8'h00, d3}, -1);
		check_val(seg, e, "seg");
		send('{8'h70, 8'h7B}, -1);
		check_val(seg, {32'h0, rev8(d3)}, "seg");
		send('{8'h70, 8'h41}, -1);
		check_val(seg, 40'h0, "seg");
		send('{8'h70, 8'h49}, -1);
		check_val(seg, {32'h0, rev8(d3)}, "seg");
		for (int m = 0; m < 6; m++) begin
			send('{8'h70, (m > 2) ? 8'hD9 : 8'hC9, 8'h70 | 8'(m % 3 + 1)}, -1);
			k = 0;
			n = 0;
			while (seg === 40'h0 && k < 200) begin
				@(posedge clk);
				k++;
			end
			while (seg !== 40'h0 && k < 400) begin
				@(posedge clk);
				k++;
			end
			while (seg === 40'h0 && n < 200) begin
				@(posedge clk);
				n++;
			end
			check_val(40'(n), 40'(DV[m] >> 1), "blink");
		end
		// Alternate bank blink swaps row 2 and row 0 each half period
		send('{8'h70, 8'h75}, -1);
		k = 0;
		n = 0;
		repeat (5 * DV[3]) begin
			@(posedge clk);
			if (seg === e)
				n++;
			else if (seg === {32'h0, rev8(d3)})
				k++;
		end
		check_val(40'(n), 40'(5 * (DV[3] >> 1)), "alt");
		check_val(40'(k), 40'(5 * (DV[3] >> 1)), "alt");
		for (int m = 0; m < 4; m++) begin
			send('{8'h70, 8'hF0, MODES[m], {5'h1C, pins}, 8'h26, 8'($urandom)}, -1);
			reg_op(0, 8'h04, {5'h0, pins + 3'h1, 2'h0, INC[m] - 6'h02});
		end
		final_report();
	end
endmodule
